// ### core/wtm_core.v
/*
  Device-side write training path and mode-register file.
  Training writes load eight beats per command into the training FIFO;
  mode-set commands load the ten mode registers by bank code.
  Assumes commands arrive on mclk from the controller's logic, and that the
  data pins and the data clock come from outside the mclk domain.
*/
`timescale 1ns/1ps
`include "wtm_defines.vh"

module wtm_core #(
  parameter DEPTH = 6,
  parameter PTR_W = 3,
  parameter DQ_W = 32,
  parameter LANE_W = 4,
  parameter PEND_W = 8,
  parameter [3:0] VENDOR_CODE = 4'hA
) (
  // clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // command port
  input wire cmdValid,
  input wire [2:0] cmdCode,
  input wire [3:0] bankSelect,
  input wire [12:0] cmdAddr,
  // data clock and data pins
  input wire wckIn,
  input wire [DQ_W-1:0] dqIn,
  input wire [LANE_W-1:0] inversionPinN,
  // error-detect pins, two-way
  input wire [LANE_W-1:0] errIn,
  output reg [LANE_W-1:0] errOut,
  output reg [LANE_W-1:0] errOe,
  // pin state
  output reg termActive,
  output reg burstActive,
  // training readback
  output reg [DQ_W+2*LANE_W-1:0] fifoRdData,
  output reg fifoRdValid,
  output reg [7:0] checkOut,
  // identification readout
  output reg [7:0] idWord
);

  localparam ENTRY_W = DQ_W + 2 * LANE_W;
  localparam CRC_IN_W = DQ_W + LANE_W;
  localparam ADDR_W = PTR_W + `WTM_BEAT_W;
  localparam WORDS = DEPTH * `WTM_BURST_LEN;
  localparam integer LAST_IDX = DEPTH - 1;
  localparam integer BURST_INT = `WTM_BURST_LEN;
  localparam integer BURST_INT_LESS = `WTM_BURST_LEN - 1;
  // cut to the counter widths on purpose; depth and burst length always fit
  localparam [PTR_W-1:0] LAST_PTR = LAST_IDX[PTR_W-1:0];
  localparam [PEND_W-1:0] BURST_BEATS = BURST_INT[PEND_W-1:0];
  localparam [PEND_W-1:0] BURST_LESS_ONE = BURST_INT_LESS[PEND_W-1:0];
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_READ = 2'b10;

  // ****************************************
  // decoding helpers
  // ****************************************

  // bank code to register slot; undefined codes map to no slot
  function [3:0] slotOf;
    input [3:0] bank;
    begin
      if (bank <= `WTM_BANK_LAST_STD) begin
        slotOf = bank;
      end else if (bank == `WTM_BANK_RSVD) begin
        slotOf = `WTM_SLOT_RSVD;
      end else if (bank == `WTM_BANK_ENABLE) begin
        slotOf = `WTM_SLOT_ENABLE;
      end else begin
        slotOf = `WTM_SLOT_NONE;
      end
    end
  endfunction

  // serial check code over one beat, msb first
  function [7:0] crcStep;
    input [7:0] c;
    input [CRC_IN_W-1:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c;
      for (i = CRC_IN_W - 1; i >= 0; i = i - 1) begin
        r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? `WTM_CRC_POLY : 8'h00);
      end
      crcStep = r;
    end
  endfunction

  // ****************************************
  // mode registers
  // ****************************************
  reg [`WTM_MR_WIDTH-1:0] modeReg [0:`WTM_MR_COUNT-1];
  wire [3:0] wrSlot;
  wire modeWrite;
  integer k;

  assign wrSlot = slotOf(bankSelect);
  assign modeWrite = cmdValid && (cmdCode == `WTM_CMD_MODE_SET) && (wrSlot != `WTM_SLOT_NONE);

  // only the mode-set command writes here; nothing here reaches the FIFO or any array
  // reset clears them so control state is defined, though software must program all
  always @(posedge mclk) begin
    if (rst) begin
      for (k = 0; k < `WTM_MR_COUNT; k = k + 1) begin
        modeReg[k] <= {`WTM_MR_WIDTH{1'b0}};
      end
    end else if (ce && modeWrite) begin
      modeReg[wrSlot] <= {1'b0, cmdAddr[`WTM_MR_DATA_MSB:0]};
    end
  end

  // fields steering the training path
  wire [2:0] latSetting = modeReg[`WTM_SLOT_LATENCY][`WTM_LAT_MSB:`WTM_LAT_LSB];
  wire writeInvEn = modeReg[`WTM_SLOT_DRIVE][`WTM_WINV_BIT];
  wire dataTermEn = |modeReg[`WTM_SLOT_DRIVE][`WTM_TERM_MSB:`WTM_TERM_LSB];
  wire strobeMode = modeReg[`WTM_SLOT_CLOCKING][`WTM_STROBE_BIT];
  wire [1:0] infoSel = modeReg[`WTM_SLOT_CLOCKING][`WTM_INFO_MSB:`WTM_INFO_LSB];
  wire writeCheckEn = modeReg[`WTM_SLOT_CHECK][`WTM_WCHK_BIT];
  wire readCheckEn = modeReg[`WTM_SLOT_CHECK][`WTM_RCHK_BIT];
  wire [3:0] holdPattern = modeReg[`WTM_SLOT_CHECK][`WTM_HOLD_MSB:`WTM_HOLD_LSB];

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [DQ_W+2*LANE_W:0] pinsStable;
  wire wckS = pinsStable[DQ_W+2*LANE_W];
  wire [LANE_W-1:0] errS = pinsStable[DQ_W+2*LANE_W-1:DQ_W+LANE_W];
  wire [LANE_W-1:0] invS = pinsStable[DQ_W+LANE_W-1:DQ_W];
  wire [DQ_W-1:0] dqS = pinsStable[DQ_W-1:0];

  wtm_sync #(
    .WIDTH(DQ_W + 2 * LANE_W + 1)
  ) uPins (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .async({wckIn, errIn, inversionPinN, dqIn}),
    .stable(pinsStable)
  );

  // ****************************************
  // write latency line
  // ****************************************
  reg [7:0] latLine;
  reg wckPrev;
  wire trainWrCmd = cmdValid && (cmdCode == `WTM_CMD_TRAIN_WR);
  wire [2:0] latIdx = (latSetting == 3'h0) ? 3'h0 : latSetting - 3'h1;
  wire launch = latLine[latIdx];
  wire wckEdge = wckS ^ wckPrev;

  // training writes need no address; each enters the latency line as one bit
  always @(posedge mclk) begin
    if (rst) begin
      latLine <= 8'h00;
      wckPrev <= 1'b0;
    end else if (ce) begin
      latLine <= {latLine[6:0], trainWrCmd};
      wckPrev <= wckS;
    end
  end

  // ****************************************
  // beat capture
  // ****************************************
  reg [PEND_W-1:0] beatsLeft;
  reg [PEND_W-1:0] next_beatsLeft;
  reg [`WTM_BEAT_W-1:0] beatIdx;
  reg [PTR_W-1:0] wrPtr;
  reg [7:0] crcAcc;
  reg [7:0] crcStore [0:DEPTH-1];
  integer m;
  wire takeBeat = wckEdge && (beatsLeft != {PEND_W{1'b0}});
  wire [LANE_W-1:0] invEff = writeInvEn ? invS : {LANE_W{1'b1}};
  wire [LANE_W-1:0] errEff = writeCheckEn ? errS : {LANE_W{1'b1}};
  wire [ENTRY_W-1:0] beatWord = {errEff, invEff, dqS};
  wire [7:0] crcSeed = (beatIdx == {`WTM_BEAT_W{1'b0}}) ? `WTM_CRC_INIT : crcAcc;
  wire [7:0] crcNext = crcStep(crcSeed, {invEff, dqS});
  wire lastBeat = takeBeat && (beatIdx == `WTM_LAST_BEAT);

  // pending beats only grow on a launch and shrink per beat: no command cuts a burst
  always @* begin
    next_beatsLeft = beatsLeft;
    if (launch && takeBeat) begin
      next_beatsLeft = beatsLeft + BURST_LESS_ONE;
    end else if (launch) begin
      next_beatsLeft = beatsLeft + BURST_BEATS;
    end else if (takeBeat) begin
      next_beatsLeft = beatsLeft - {{(PEND_W-1){1'b0}}, 1'b1};
    end
  end

  // beats land in the entry at the write pointer; pointer wraps after the last entry
  always @(posedge mclk) begin
    if (rst) begin
      beatsLeft <= {PEND_W{1'b0}};
      beatIdx <= {`WTM_BEAT_W{1'b0}};
      wrPtr <= {PTR_W{1'b0}};
      crcAcc <= `WTM_CRC_INIT;
    end else if (ce) begin
      beatsLeft <= next_beatsLeft;
      if (takeBeat) begin
        beatIdx <= beatIdx + {{(`WTM_BEAT_W-1){1'b0}}, 1'b1};
        crcAcc <= crcNext;
      end
      if (lastBeat) begin
        wrPtr <= (wrPtr == LAST_PTR) ? {PTR_W{1'b0}} : wrPtr + {{(PTR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // computed check code is kept per entry for a later training read, never returned now
  always @(posedge mclk) begin
    if (rst) begin
      for (m = 0; m < DEPTH; m = m + 1) begin
        crcStore[m] <= 8'h00;
      end
    end else if (ce && lastBeat) begin
      crcStore[wrPtr] <= crcNext;
    end
  end

  // ****************************************
  // training read sequencer
  // ****************************************
  reg [1:0] rdState;
  reg [`WTM_BEAT_W-1:0] rdBeat;
  reg [PTR_W-1:0] rdPtr;
  reg rdPending;
  reg [PTR_W-1:0] rdEntry;
  wire trainRdCmd = cmdValid && (cmdCode == `WTM_CMD_TRAIN_RD);
  wire rdEn = (rdState == ST_READ);
  wire [ENTRY_W-1:0] memRdData;

  // walks eight beats of the entry at the read pointer, one per cycle
  always @(posedge mclk) begin
    if (rst) begin
      rdState <= ST_IDLE;
      rdBeat <= {`WTM_BEAT_W{1'b0}};
      rdPtr <= {PTR_W{1'b0}};
      rdPending <= 1'b0;
      rdEntry <= {PTR_W{1'b0}};
    end else if (ce) begin
      rdPending <= rdEn;
      rdEntry <= rdPtr;
      case (rdState)
        ST_IDLE: begin
          rdBeat <= {`WTM_BEAT_W{1'b0}};
          if (trainRdCmd) begin
            rdState <= ST_READ;
          end
        end
        ST_READ: begin
          rdBeat <= rdBeat + {{(`WTM_BEAT_W-1){1'b0}}, 1'b1};
          if (rdBeat == `WTM_LAST_BEAT) begin
            rdState <= ST_IDLE;
            rdPtr <= (rdPtr == LAST_PTR) ? {PTR_W{1'b0}} : rdPtr + {{(PTR_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          rdState <= ST_IDLE;
        end
      endcase
    end
  end

  wtm_mem #(
    .WIDTH(ENTRY_W),
    .WORDS(WORDS),
    .ADDR_W(ADDR_W)
  ) uFifo (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wrEn(takeBeat),
    .wrAddr({wrPtr, beatIdx}),
    .wrData(beatWord),
    .rdEn(rdEn),
    .rdAddr({rdPtr, rdBeat}),
    .rdData(memRdData)
  );

  // ****************************************
  // registered outputs
  // ****************************************

  // error pins keep the hold pattern except in strobe mode, where they toggle with the data clock
  // termination returns as soon as no beats are pending; stray beats then find no slot
  always @(posedge mclk) begin
    if (rst) begin
      errOut <= {LANE_W{1'b0}};
      errOe <= {LANE_W{1'b0}};
      termActive <= 1'b0;
      burstActive <= 1'b0;
      fifoRdData <= {ENTRY_W{1'b0}};
      fifoRdValid <= 1'b0;
      checkOut <= 8'h00;
      idWord <= 8'h00;
    end else if (ce) begin
      errOe <= {LANE_W{1'b1}};
      errOut <= strobeMode ? {LANE_W{wckS}} : holdPattern;
      termActive <= dataTermEn && (next_beatsLeft == {PEND_W{1'b0}});
      burstActive <= (next_beatsLeft != {PEND_W{1'b0}});
      fifoRdValid <= rdPending;
      if (rdPending) begin
        fifoRdData <= memRdData;
        checkOut <= readCheckEn ? crcStore[rdEntry] : 8'h00;
      end
      // identification readout reports vendor nibble and FIFO depth
      idWord <= (infoSel == `WTM_INFO_ID) ? {VENDOR_CODE, DEPTH[3:0]} : 8'h00;
    end
  end

endmodule // wtm_core

// ### core/wtm_defines.vh
/*
  Constants for the write-training FIFO and mode-register block:
  command codes, register slots, field positions and check-code polynomial.
  Assumes it is included by the design files and defines nothing else.
*/
`ifndef WTM_DEFINES_VH
`define WTM_DEFINES_VH

// ****************************************
// command codes on the command port
// ****************************************
`define WTM_CMD_NOP       3'h0
`define WTM_CMD_TRAIN_WR  3'h1
`define WTM_CMD_TRAIN_RD  3'h2
`define WTM_CMD_MODE_SET  3'h3

// ****************************************
// mode register slots and bank codes
// ****************************************
`define WTM_MR_COUNT      10
`define WTM_MR_WIDTH      13
`define WTM_MR_DATA_MSB   11
`define WTM_SLOT_NONE     4'hF
`define WTM_BANK_LAST_STD 4'h7
`define WTM_BANK_RSVD 4'hE
`define WTM_BANK_ENABLE 4'hF
`define WTM_SLOT_RSVD 4'h8
`define WTM_SLOT_ENABLE 4'h9
`define WTM_SLOT_LATENCY 0
`define WTM_SLOT_DRIVE 1
`define WTM_SLOT_CLOCKING 3
`define WTM_SLOT_CHECK 4

// ****************************************
// field positions inside the mode registers
// ****************************************
`define WTM_LAT_MSB 2
`define WTM_LAT_LSB 0
`define WTM_WINV_BIT      8
`define WTM_TERM_MSB      3
`define WTM_TERM_LSB      2
`define WTM_STROBE_BIT    5
`define WTM_INFO_MSB      7
`define WTM_INFO_LSB      6
`define WTM_INFO_ID       2'h1
`define WTM_WCHK_BIT      10
`define WTM_RCHK_BIT      9
`define WTM_HOLD_MSB      3
`define WTM_HOLD_LSB      0

// ****************************************
// burst shape and check code
// ****************************************
`define WTM_BURST_LEN     8
`define WTM_BEAT_W        3
`define WTM_LAST_BEAT     3'h7
`define WTM_CRC_POLY      8'h07
`define WTM_CRC_INIT      8'h00

`endif

// ### core/wtm_mem.v
/*
  Small single-port-write, registered-read memory holding the training FIFO beats.
  Assumes write and read addresses are always in range.
*/
`timescale 1ns/1ps
`include "wtm_defines.vh"

module wtm_mem #(
  parameter WIDTH = 40,
  parameter WORDS = 48,
  parameter ADDR_W = 6
) (
  // clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // write side
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  // read side, data one cycle after the request
  input wire rdEn,
  input wire [ADDR_W-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);

  reg [WIDTH-1:0] store [0:WORDS-1];

  // storage has no reset: contents are defined only once written
  always @(posedge mclk) begin
    if (ce && wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // registered read port
  always @(posedge mclk) begin
    if (rst) begin
      rdData <= {WIDTH{1'b0}};
    end else if (ce && rdEn) begin
      rdData <= store[rdAddr];
    end
  end

endmodule // wtm_mem

// ### core/wtm_sync.v
/*
  Three-stage synchroniser for pins from outside the clock domain.
  Assumes a free-running mclk; a bit's change is accepted once stages two and three agree.
*/
`timescale 1ns/1ps
`include "wtm_defines.vh"

module wtm_sync #(
  parameter WIDTH = 1
) (
  // clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // raw pin levels and filtered result
  input wire [WIDTH-1:0] async,
  output reg [WIDTH-1:0] stable
);

  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;

  // s1 feeds only s2; the agreement filter looks at stages two and three
  always @(posedge mclk) begin
    if (rst) begin
      s1 <= {WIDTH{1'b0}};
      s2 <= {WIDTH{1'b0}};
      s3 <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
    end else if (ce) begin
      s1 <= async;
      s2 <= s1;
      s3 <= s2;
      stable <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & stable);
    end
  end

endmodule // wtm_sync

// ### verif/testbench.sv
/*
  bench top: mode programming, training writes and readback.
  assumes wtm_core on a 25 MHz clock and the controller model for data.
*/
`timescale 1ns/1ps
`include "wtm_defines.vh"
module testbench;
  localparam [3:0] VendorCode = 4'h3; // arbitrary value
  reg mclk, rst, cmdValid, go;
  reg [2:0] cmdCode;
  reg [3:0] bankSelect;
  reg [12:0] cmdAddr;
  reg [31:0] base;
  reg [4:0] beats;
  wire wck, mBusy, termActive, burstActive, fifoRdValid;
  wire [31:0] dq;
  wire [3:0] invN, errOut, errOe, errWire;
  wire [39:0] fifoRdData;
  wire [7:0] checkOut, idWord;
  integer miscompares, numChecks, n, w;
  // a lane nobody drives shows the inverse level
  assign errWire = (errOe & errOut) | (~errOe & ~errOut);
  wtm_core #(.VENDOR_CODE(VendorCode)) uut (.mclk(mclk), .rst(rst), .ce(1'b1), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .bankSelect(bankSelect), .cmdAddr(cmdAddr), .wckIn(wck), .dqIn(dq),
    .inversionPinN(invN), .errIn(errWire), .errOut(errOut), .errOe(errOe), .termActive(termActive),
    .burstActive(burstActive), .fifoRdData(fifoRdData), .fifoRdValid(fifoRdValid),
    .checkOut(checkOut), .idWord(idWord));
  wtm_ctrl_model ctrl (.go(go), .base(base), .beats(beats), .wck(wck), .dq(dq), .invN(invN), .busy(mBusy));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task tick;
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task check(input [63:0] what, input [39:0] exp, input [39:0] got);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        $display("ERROR %0s expected %h seen %h", what, exp, got);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task cmd(input [2:0] c, input [3:0] b, input [12:0] a);
    begin
      tick;
      cmdValid = 1'b1;
      cmdCode = c;
      bankSelect = b;
      cmdAddr = a;
      tick;
      cmdValid = 1'b0;
    end
  endtask
  task ms(input [3:0] b, input [12:0] a);
    cmd(`WTM_CMD_MODE_SET, b, a);
  endtask
  function [7:0] crc(input [7:0] c0, input [35:0] d);
    integer j;
    begin
      crc = c0;
      for (j = 35; j >= 0; j = j - 1)
        crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[j]) ? `WTM_CRC_POLY : 8'h00);
    end
  endfunction
  // the frame starts only once the burst is pending, so no beat is lost
  task wr(input [31:0] b, input [4:0] nb);
    begin
      cmd(`WTM_CMD_TRAIN_WR, 4'h0, 13'h0000);
      for (n = 0; !burstActive && n < 20; n = n + 1)
        tick;
      base = b;
      beats = nb;
      go = 1'b1;
      #40;
      go = 1'b0;
      for (n = 0; (mBusy || burstActive) && n < 300; n = n + 1)
        tick;
      check("burst", 40'h0, burstActive);
      check("term", 40'h1, termActive);
    end
  endtask
  task rdchk(input [31:0] b, input invOn, input [3:0] errv, input crcOn);
    reg [7:0] c;
    reg [3:0] iv;
    integer k;
    begin
      c = `WTM_CRC_INIT;
      // the model puts each beat's low data nibble on the inversion lanes
      for (k = 0; k < 8; k = k + 1) begin
        iv = invOn ? b[3:0] + k[3:0] : 4'hF;
        c = crc(c, {iv, b + k});
      end
      repeat (4) tick;
      cmd(`WTM_CMD_TRAIN_RD, 4'h0, 13'h0000);
      for (k = 0; !fifoRdValid && k < 6; k = k + 1)
        tick;
      for (k = 0; k < 8; k = k + 1) begin
        iv = invOn ? b[3:0] + k[3:0] : 4'hF;
        check("rdValid", 40'h1, fifoRdValid);
        check("fifoData", {errv, iv, b + k}, fifoRdData);
        check("checkOut", crcOn ? c : 8'h00, checkOut);
        tick;
      end
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task tModes;
    begin
      check("errOe", 40'hF, errOe);
      ms(4'h0, 13'h0002);
      ms(4'h1, 13'h0004);
      ms(4'h2, 13'h0000);
      ms(4'h3, 13'h1040);
      ms(4'h4, 13'h0605);
      for (n = 5; n < 8; n = n + 1)
        ms(n[3:0], 13'h0000);
      ms(4'hE, 13'h0000);
      ms(4'hF, 13'h0000);
      tick;
      check("idWord", {VendorCode, 4'h6}, idWord);
      check("term", 40'h1, termActive);
      check("errOut", 40'h5, errOut);
      ms(4'hC, 13'h000A);
      tick;
      check("errOut", 40'h5, errOut);
      // strobe mode: error pins follow the idle data clock, low between frames
      ms(4'h3, 13'h0060);
      tick;
      check("errOut", 40'h0, errOut);
      ms(4'h3, 13'h1040);
      $display("test modes done");
    end
  endtask
  task tSingle;
    begin
      wr(32'hA5C30F00, 5'd8);
      rdchk(32'hA5C30F00, 1'b0, 4'h5, 1'b1);
      $display("test single done");
    end
  endtask
  task tChain;
    begin
      ms(4'h1, 13'h0104);
      ms(4'h4, 13'h0205);
      cmd(`WTM_CMD_TRAIN_WR, 4'h0, 13'h0000);
      wr(32'h0F0F0000, 5'd18);
      rdchk(32'h0F0F0000, 1'b1, 4'hF, 1'b1);
      rdchk(32'h0F0F0008, 1'b1, 4'hF, 1'b1);
      $display("test chain done");
    end
  endtask
  task tWrap;
    begin
      for (w = 0; w < 7; w = w + 1)
        wr(32'h30000000 + 16 * w, 5'd8);
      rdchk(32'h30000060, 1'b1, 4'hF, 1'b1);
      $display("test wrap done");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #300000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    miscompares = 0;
    numChecks = 0;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdCode = 3'h0;
    bankSelect = 4'h0;
    cmdAddr = 13'h0000;
    go = 1'b0;
    base = 32'h0;
    beats = 5'h0;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    tick;
    tModes;
    tSingle;
    tChain;
    tWrap;
    summarize;
  end
endmodule // testbench

// ### verif/wtm_core_asserts.sv
/*
  port checker for the write training block.
  assumes ce held high and legal command spacing from the controller.
*/
`timescale 1ns/1ps
module wtm_core_asserts #(
  parameter DEPTH = 6,
  parameter LANE_W = 4,
  parameter [3:0] VENDOR_CODE = 4'hA
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // command port
  input wire cmdValid,
  input wire [2:0] cmdCode,
  // watched outputs
  input wire [LANE_W-1:0] errOe,
  input wire termActive,
  input wire burstActive,
  input wire fifoRdValid,
  input wire [7:0] idWord
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_err_driven: assert property (!$past(rst) |-> &errOe)
    else $error("error pins released");
  a_wr_launch: assert property ((cmdValid && cmdCode == 3'h1) |-> ##[2:9] burstActive)
    else $error("training write never started");
  a_burst_whole: assert property ($rose(burstActive) |-> burstActive[*6])
    else $error("burst cut short");
  a_term_off: assert property (burstActive |-> !termActive)
    else $error("termination during burst");
  a_rd_len: assert property ($rose(fifoRdValid) |-> fifoRdValid[*8] ##1 !fifoRdValid)
    else $error("readback not eight beats");
  a_rd_lat: assert property ((cmdValid && cmdCode == 3'h2 && !fifoRdValid) |->
    ##1 !fifoRdValid[*2] ##1 fifoRdValid)
    else $error("readback latency wrong");
  a_id_value: assert property (idWord == 8'h00 || idWord == {VENDOR_CODE, DEPTH[3:0]})
    else $error("bad identification word");
  // the mode file drives idWord one edge after the taking edge
  a_id_cause: assert property ($changed(idWord) |->
    $past(cmdValid, 2) && $past(cmdCode, 2) == 3'h3)
    else $error("mode output changed without mode set");
endmodule // wtm_core_asserts

bind wtm_core wtm_core_asserts #(.DEPTH(DEPTH), .LANE_W(LANE_W), .VENDOR_CODE(VENDOR_CODE)) chk (
  .mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode), .errOe(errOe),
  .termActive(termActive), .burstActive(burstActive), .fifoRdValid(fifoRdValid), .idWord(idWord));

// ### verif/wtm_ctrl_model.sv
/*
  controller model: data clock and data pins for training bursts.
  assumes the bench raises go once the burst is pending.
*/
`timescale 1ns/1ps
module wtm_ctrl_model (
  // frame request
  input wire go,
  input wire [31:0] base,
  input wire [4:0] beats,
  // data clock and pins
  output reg wck,
  output reg [31:0] dq,
  output reg [3:0] invN,
  output reg busy
);
  integer k;
  // data settles half a beat before each edge; clock stands still between frames
  initial begin
    wck = 1'b0;
    dq = 32'h0;
    invN = 4'h0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      for (k = 0; k < beats; k = k + 1) begin
        dq = base + k;
        invN = dq[3:0]; // inversion lanes follow the low data nibble
        #80;
        wck = ~wck;
        #80;
      end
      // released pins must not look like the last beat
      dq = ~dq;
      invN = ~invN;
      busy = 1'b0;
    end
  end
endmodule // wtm_ctrl_model
